// ===== bench/bce_host.sv
// Bus master model standing in for the CPU or DMA controller.
`timescale 1ns/1ps
module bce_host (
  input wire logic clk, // bus clock
  output logic [4:0] avs_address, // byte address
  output logic avs_read, // read request
  output logic avs_write, // write request
  output logic [31:0] avs_writedata, // write data
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest // stall from the engine
);
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
  end
  // One byte per access, held until the stall drops.
  task automatic xfer(input logic wr, input logic [4:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, d};
    // Stall and read data are both taken at the rising edge that ends a wait.
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released data must not look like it still holds the last byte.
    avs_writedata <= ~avs_writedata;
  endtask : xfer
endmodule : bce_host

// ===== bench/tb.sv
// Self-checking testbench for the block cipher engine.
`timescale 1ns/1ps
module tb;
  import bce_pkg::*;
  localparam logic [4:0] A_CTRL = 5'h00, A_FLAGS = 5'h04, A_STATE = 5'h08;
  localparam logic [4:0] A_KEY = 5'h0C, A_INT = 5'h10;
  localparam logic [127:0] KEY0 = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] CT = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  localparam logic [127:0] LK = 128'h13111D7FE3944A17F307A78B4D2B30C5;
  logic clk, nrst;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  bce_evt_t evt;
  int fails, samples_checked, cyc, t0;
  int km[16], sm[16];
  logic [15:0] lfsr_r = 16'h77BA;

  bce_core u_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .evt_o(evt));
  bce_host u_host (.clk(clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic conclude();
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string n);
    logic [7:0] q;
    u_host.xfer(1'b0, a, 8'h00, q);
    chk(n, {24'h000000, e}, {24'h000000, q});
  endtask : rdc
  task automatic load(input logic [4:0] a, input logic [127:0] v);
    for (int i = 0; i < 16; i++) wr(a, v[127 - 8 * i -: 8]);
  endtask : load
  task automatic rdv(input logic [4:0] a, input logic [127:0] v, input string n);
    for (int i = 0; i < 16; i++) rdc(a, v[127 - 8 * i -: 8], n);
  endtask : rdv
  // Times a run from its starting edge to the completion pulse.
  task automatic run_wait();
    int n;
    @(negedge clk);
    t0 = cyc;
    rdc(A_KEY, 8'h00, "key_busy");
    wr(A_KEY, 8'h5A);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (evt.dma_trig !== 1'b1 && n < 500);
    chk("run_cycles", 32'd375, 32'(cyc - t0));
    @(negedge clk);
    chk("irq", 32'h1, {31'h0, evt.irq_req});
    chk("dma_pulse", 32'h0, {31'h0, evt.dma_trig});
  endtask : run_wait

  initial begin
    #200000;
    fails++;
    conclude();
  end

  initial begin
    int seen;
    fails = 0;
    samples_checked = 0;
    nrst = 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rdc(A_CTRL, 8'h00, "ctrl_rst");
    rdc(A_FLAGS, 8'h00, "flags_rst");
    rdc(A_INT, 8'h00, "int_rst");
    wr(5'h14, 8'hFF);
    rdc(5'h14, 8'h00, "reserved");
    rdc(5'h09, 8'h00, "unaligned");
    for (int i = 0; i < 16; i++) begin
      lfsr_r = lfsr(lfsr_r);
      km[i] = lfsr_r[7:0];
      sm[i] = lfsr_r[15:8];
      wr(A_KEY, 8'(km[i]));
      wr(A_STATE, 8'(sm[i]));
    end
    for (int i = 0; i < 16; i++) begin
      rdc(A_KEY, 8'(km[i]), "key_mem");
      rdc(A_STATE, 8'(sm[i]), "state_mem");
    end
    rdc(A_KEY, 8'(km[0]), "key_wrap");
    wr(A_CTRL, 8'h80);
    rdc(A_FLAGS, 8'h80, "flags_count_err");
    rdc(A_CTRL, 8'h00, "ctrl_no_start");
    rdc(A_KEY, 8'(km[0]), "key_ptr_clear");
    wr(A_FLAGS, 8'h80);
    rdc(A_FLAGS, 8'h00, "flags_w1c");
    wr(A_CTRL, 8'h20);
    rdc(A_CTRL, 8'h00, "ctrl_swrst");
    rdc(A_KEY, 8'h00, "key_swrst");
    wr(A_CTRL, 8'h20);
    for (int p = 0; p < 2; p++) begin
      wr(A_CTRL, 8'h04);
      for (int i = 0; i < 16; i++) begin
        lfsr_r = lfsr(lfsr_r);
        sm[i] = (p == 0) ? lfsr_r[7:0] : sm[i] ^ lfsr_r[7:0];
        wr(A_STATE, lfsr_r[7:0]);
      end
    end
    rdc(A_CTRL, 8'h04, "ctrl_xor");
    wr(A_STATE, 8'h00);
    rdc(A_STATE, 8'(sm[1]), "xor_rd_ptr");
    wr(A_CTRL, 8'h00);
    for (int i = 0; i < 16; i++) rdc(A_STATE, 8'(sm[i]), "xor_load");
    wr(A_CTRL, 8'h20);
    wr(A_INT, 8'h01);
    rdc(A_INT, 8'h01, "int_level");
    wr(A_CTRL, 8'h00);
    load(A_KEY, KEY0);
    load(A_STATE, PT);
    wr(A_CTRL, 8'h80);
    run_wait();
    rdc(A_FLAGS, 8'h01, "flags_ready");
    rdc(A_CTRL, 8'h00, "ctrl_done");
    rdc(A_STATE, CT[127:120], "ct_byte0");
    rdc(A_FLAGS, 8'h00, "ready_cleared");
    chk("irq_low", 32'h0, {31'h0, evt.irq_req});
    wr(A_CTRL, 8'h00);
    rdv(A_STATE, CT, "ciphertext");
    rdv(A_KEY, LK, "last_subkey");
    wr(A_CTRL, 8'h20);
    rdc(A_INT, 8'h00, "int_swrst");
    wr(A_INT, 8'h02);
    wr(A_CTRL, 8'h50);
    load(A_KEY, LK);
    load(A_STATE, CT);
    run_wait();
    rdc(A_CTRL, 8'h50, "ctrl_auto_done");
    wr(A_FLAGS, 8'h01);
    rdc(A_FLAGS, 8'h00, "ready_w1c");
    rdv(A_STATE, PT, "plaintext");
    rdv(A_KEY, KEY0, "orig_key");
    wr(A_CTRL, 8'h20);
    load(A_KEY, KEY0);
    load(A_STATE, PT);
    wr(A_CTRL, 8'h80);
    rdc(A_CTRL, 8'h80, "ctrl_running");
    rdc(A_FLAGS, 8'h80, "flags_read_err");
    wr(A_FLAGS, 8'h80);
    wr(A_CTRL, 8'h80);
    wr(A_CTRL, 8'h00);
    seen = 0;
    repeat (400) begin
      @(negedge clk);
      if (evt.dma_trig !== 1'b0) seen++;
    end
    chk("abort_no_dma", 32'h0, 32'(seen));
    rdc(A_FLAGS, 8'h80, "flags_busy_err");
    conclude();
  end
endmodule : tb

// ===== design/bce_core.sv
// Block cipher engine: register slave, key/state memories and round logic.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "bce_regs.svh"
// Overview of operation
// - Result is ready 375 clock cycles after a start.
// - Key and state are two separate sixteen-byte memories with own ports.
// - Each memory has hidden 4-bit read and write pointers stepping per access.
// - Any control register access clears all four pointers.
// - A pointer wraps to zero after its sixteenth access.
// - Combine mode XORs state writes into stored bytes, else overwrite.
// - In combine mode a state write steps both state pointers.
// - Key and state ports are refused while processing runs.
// - Key memory ends as final subkey after encrypt, original after decrypt.
// - Completion sets the ready flag and requests an enabled interrupt.
// - Completion issues a DMA transfer trigger.
// - Start bit begins, reads one while running, zero aborts, flags clear it.
// - Auto mode starts once the state memory is fully loaded.
// - Soft reset bit clears everything next edge and self-clears.
// - Direction bit selects encryption at zero, decryption at one.
// - Start with access count not a multiple of sixteen sets error.
// - Control access while running sets error; error is write-one-clear.
// - First state byte read or writing one clears the ready flag.
// - Nonzero priority field requests an interrupt while ready is set.
module bce_core (
  input wire logic clk, // 250 MHz clock
  input wire logic nrst, // async reset, active low
  input wire logic [4:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  output bce_pkg::bce_evt_t evt_o // interrupt level and DMA pulse
);
  import bce_pkg::*;
  logic [7:0] key_mem [16];
  logic [7:0] state_mem [16];
  bce_ctrl_t ctrl_r;
  bce_ctrl_t wctl;
  logic err_r, rdy_r, ack_r, armed_r, irq_r, dma_r;
  logic [1:0] irq_priority_level_r;
  logic [3:0] key_rp_r, key_wp_r, st_rp_r, st_wp_r, acc_cnt_r;
  logic [8:0] run_cnt_r;
  logic [7:0] rcon_r, rd_nxt;
  logic [31:0] rdata_r;
  logic [127:0] st_v, key_v, st_nxt, key_nxt, t;
  logic req, acc, wr, rd, map_ok, busy, clr;
  logic hit_ctrl, hit_flags, hit_state, hit_key, hit_int;
  logic ctrl_acc, ctrl_wr, flags_wr, st_wr, st_rd, key_wr, key_rd;
  logic start_req, auto_go, start_go, err_set, done_p, frac_bad;
  logic [2:0] idx;
  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction : xt
  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p, x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction : gmul
  function automatic logic [7:0] rl(input logic [7:0] a, input int n);
    logic [15:0] d;
    d = {a, a} << n;
    return d[15:8];
  endfunction : rl
  // Field inverse as x^254 keeps the S-box free of lookup tables.
  function automatic logic [7:0] sbox(input logic [7:0] a, input logic inv);
    logic [7:0] x, p, q;
    x = inv ? (rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ 8'h05) : a;
    p = 8'h01;
    q = x;
    for (int i = 1; i < 8; i++) begin
      q = gmul(q, q);
      p = gmul(p, q);
    end
    if (!inv) p = p ^ rl(p, 1) ^ rl(p, 2) ^ rl(p, 3) ^ rl(p, 4) ^ 8'h63;
    return p;
  endfunction : sbox
  function automatic logic [127:0] sub_all(input logic [127:0] v,
                                           input logic inv);
    logic [127:0] o;
    o = '0;
    for (int i = 0; i < 16; i++) o[8*i +: 8] = sbox(v[8*i +: 8], inv);
    return o;
  endfunction : sub_all
  function automatic logic [127:0] shift(input logic [127:0] v,
                                         input logic inv);
    logic [127:0] o;
    int j;
    o = '0;
    for (int i = 0; i < 16; i++) begin
      j = (i % 4) + 4 * (((i / 4) + (i % 4)) % 4);
      if (inv) o[8*j +: 8] = v[8*i +: 8];
      else o[8*i +: 8] = v[8*j +: 8];
    end
    return o;
  endfunction : shift
  function automatic logic [127:0] mix(input logic [127:0] v,
                                       input logic inv);
    logic [127:0] o;
    logic [7:0] m [4];
    o = '0;
    m[0] = inv ? 8'h0E : 8'h02;
    m[1] = inv ? 8'h0B : 8'h03;
    m[2] = inv ? 8'h0D : 8'h01;
    m[3] = inv ? 8'h09 : 8'h01;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        o[32*c + 8*r +: 8] = gmul(v[32*c + 8*r +: 8], m[0])
          ^ gmul(v[32*c + 8*((r+1)%4) +: 8], m[1])
          ^ gmul(v[32*c + 8*((r+2)%4) +: 8], m[2])
          ^ gmul(v[32*c + 8*((r+3)%4) +: 8], m[3]);
      end
    end
    return o;
  endfunction : mix
  function automatic logic [31:0] gword(input logic [31:0] w,
                                        input logic [7:0] rc);
    logic [31:0] r;
    r = {w[7:0], w[31:8]};
    for (int i = 0; i < 4; i++) r[8*i +: 8] = sbox(r[8*i +: 8], 1'b0);
    return r ^ {24'h000000, rc};
  endfunction : gword
  // Forward step gives the next subkey, backward step the previous one.
  function automatic logic [127:0] key_step(input logic [127:0] k,
                                            input logic [7:0] rc,
                                            input logic back);
    logic [31:0] w0, w1, w2, w3;
    if (!back) begin
      w0 = k[31:0] ^ gword(k[127:96], rc);
      w1 = k[63:32] ^ w0;
      w2 = k[95:64] ^ w1;
      w3 = k[127:96] ^ w2;
    end else begin
      w3 = k[127:96] ^ k[95:64];
      w2 = k[95:64] ^ k[63:32];
      w1 = k[63:32] ^ k[31:0];
      w0 = k[31:0] ^ gword(w3, rc);
    end
    return {w3, w2, w1, w0};
  endfunction : key_step
  // Bus decode; every access costs one wait cycle, so data is registered.
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign acc = req & ack_r;
  assign wr = acc & avs_write;
  assign rd = acc & avs_read;
  assign map_ok = avs_address[1:0] == 2'h0;
  assign idx = avs_address[4:2];
  assign hit_ctrl = map_ok && idx == `BCE_IDX_CTRL;
  assign hit_flags = map_ok && idx == `BCE_IDX_FLAGS;
  assign hit_state = map_ok && idx == `BCE_IDX_STATE;
  assign hit_key = map_ok && idx == `BCE_IDX_KEY;
  assign hit_int = map_ok && idx == `BCE_IDX_INTCTRL;
  assign busy = ctrl_r.start;
  assign clr = ctrl_r.sw_reset;
  assign wctl = bce_ctrl_t'(avs_writedata[7:0] & `BCE_CTRL_WMASK);
  assign ctrl_acc = acc & hit_ctrl;
  assign ctrl_wr = wr & hit_ctrl;
  assign flags_wr = wr & hit_flags;
  assign st_wr = wr & hit_state & ~busy;
  assign st_rd = rd & hit_state & ~busy;
  assign key_wr = wr & hit_key & ~busy;
  assign key_rd = rd & hit_key & ~busy;
  assign frac_bad = acc_cnt_r != 4'h0;
  assign start_req = ctrl_wr & ~busy & wctl.start;
  // The sixteenth state byte is the last of a full load.
  assign auto_go = st_wr && st_wp_r == 4'hF && ctrl_r.auto_go && armed_r
    && acc_cnt_r == 4'hF;
  assign start_go = (start_req & ~frac_bad) | auto_go;
  assign err_set = (start_req & frac_bad) | (ctrl_acc & busy);
  assign done_p = busy && run_cnt_r == `BCE_RUN_LAST && !ctrl_acc;
  assign evt_o = '{irq_req: irq_r, dma_trig: dma_r};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) ack_r <= 1'b0;
    else ack_r <= req & ~ack_r;
  end
  always_comb begin
    rd_nxt = 8'h00;
    if (hit_ctrl) rd_nxt = ctrl_r;
    else if (hit_flags) rd_nxt = {err_r, 6'h00, rdy_r};
    else if (hit_state && !busy) rd_nxt = state_mem[st_rp_r];
    else if (hit_key && !busy) rd_nxt = key_mem[key_rp_r];
    else if (hit_int) rd_nxt = {6'h00, irq_priority_level_r};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rdata_r <= 32'h00000000;
    else if (req && !ack_r) rdata_r <= {24'h000000, rd_nxt};
  end
  assign avs_readdata = rdata_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= bce_ctrl_t'(`BCE_CTRL_RST);
    end else if (clr) begin
      ctrl_r <= bce_ctrl_t'(`BCE_CTRL_RST);
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= wctl;
        ctrl_r.start <= start_go;
      end else if (auto_go) begin
        ctrl_r.start <= 1'b1;
      end
      if (done_p || err_set) ctrl_r.start <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      irq_priority_level_r <= 2'h0;
    end else if (clr) begin
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      irq_priority_level_r <= 2'h0;
    end else begin
      // A hardware set in the same cycle as a clear wins.
      if (done_p) rdy_r <= 1'b1;
      else if ((st_rd && st_rp_r == 4'h0)
        || (flags_wr && avs_writedata[`BCE_FLAG_RDY])) rdy_r <= 1'b0;
      if (err_set) err_r <= 1'b1;
      else if (flags_wr && avs_writedata[`BCE_FLAG_ERR]) err_r <= 1'b0;
      if (wr && hit_int) irq_priority_level_r <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
      dma_r <= 1'b0;
    end else begin
      irq_r <= rdy_r && irq_priority_level_r != 2'h0 && !clr;
      dma_r <= done_p;
    end
  end
  // Pointers are four bits wide, so they wrap to zero on their own.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {key_rp_r, key_wp_r, st_rp_r, st_wp_r, acc_cnt_r} <= 20'h00000;
      armed_r <= 1'b0;
    end else if (clr) begin
      {key_rp_r, key_wp_r, st_rp_r, st_wp_r, acc_cnt_r} <= 20'h00000;
      armed_r <= 1'b0;
    end else if (ctrl_acc) begin
      {key_rp_r, key_wp_r, st_rp_r, st_wp_r} <= 16'h0000;
      armed_r <= ctrl_wr ? wctl.auto_go : ctrl_r.auto_go;
    end else begin
      if (key_rd) key_rp_r <= key_rp_r + 4'h1;
      if (key_wr) key_wp_r <= key_wp_r + 4'h1;
      if (st_rd || (st_wr && ctrl_r.combine)) st_rp_r <= st_rp_r + 4'h1;
      if (st_wr) st_wp_r <= st_wp_r + 4'h1;
      if (key_rd || key_wr || st_rd || st_wr) acc_cnt_r <= acc_cnt_r + 4'h1;
      if (auto_go) armed_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_cnt_r <= 9'h000;
      rcon_r <= `BCE_RCON_FIRST;
    end else if (clr || start_go) begin
      run_cnt_r <= 9'h000;
      rcon_r <= ctrl_wr && wctl.decrypt || !ctrl_wr && ctrl_r.decrypt ?
        `BCE_RCON_LAST : `BCE_RCON_FIRST;
    end else if (busy) begin
      run_cnt_r <= run_cnt_r + 9'h001;
      if (run_cnt_r != 9'h000 && run_cnt_r <= `BCE_ROUND_LAST)
        rcon_r <= !ctrl_r.decrypt ? xt(rcon_r) :
          (rcon_r == 8'h1B ? 8'h80 : {1'b0, rcon_r[7:1]});
    end
  end

  for (genvar i = 0; i < 16; i++) begin : g_pack
    assign st_v[8*i +: 8] = state_mem[i];
    assign key_v[8*i +: 8] = key_mem[i];
  end
  // One full round per cycle; the remaining cycles only pad out the run.
  always_comb begin
    st_nxt = st_v;
    key_nxt = key_v;
    t = '0;
    if (run_cnt_r == 9'h000) begin
      st_nxt = st_v ^ key_v;
    end else if (run_cnt_r <= `BCE_ROUND_LAST) begin
      key_nxt = key_step(key_v, rcon_r, ctrl_r.decrypt);
      t = shift(sub_all(st_v, ctrl_r.decrypt), ctrl_r.decrypt);
      if (!ctrl_r.decrypt) begin
        if (run_cnt_r != `BCE_ROUND_LAST) t = mix(t, 1'b0);
        st_nxt = t ^ key_nxt;
      end else begin
        t = t ^ key_nxt;
        if (run_cnt_r != `BCE_ROUND_LAST) t = mix(t, 1'b1);
        st_nxt = t;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) begin
        key_mem[i] <= 8'h00;
        state_mem[i] <= 8'h00;
      end
    end else if (clr) begin
      for (int i = 0; i < 16; i++) begin
        key_mem[i] <= 8'h00;
        state_mem[i] <= 8'h00;
      end
    end else if (busy && run_cnt_r <= `BCE_ROUND_LAST) begin
      for (int i = 0; i < 16; i++) begin
        key_mem[i] <= key_nxt[8*i +: 8];
        state_mem[i] <= st_nxt[8*i +: 8];
      end
    end else begin
      if (key_wr) key_mem[key_wp_r] <= avs_writedata[7:0];
      if (st_wr) state_mem[st_wp_r] <= ctrl_r.combine ?
        state_mem[st_wp_r] ^ avs_writedata[7:0] : avs_writedata[7:0];
    end
  end

  run_time_a: assert property (@(posedge clk) disable iff (!nrst)
    busy && run_cnt_r == `BCE_RUN_LAST && !ctrl_acc && !clr
    |=> !busy && rdy_r) else $error("run did not end with ready");
  ptr_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_acc |=> {key_rp_r, key_wp_r, st_rp_r, st_wp_r} == 16'h0000)
    else $error("pointers not cleared by control access");
  ptr_step_a: assert property (@(posedge clk) disable iff (!nrst)
    key_wr && !clr |=> key_wp_r == $past(key_wp_r) + 4'h1)
    else $error("key write pointer did not step");
  xor_step_a: assert property (@(posedge clk) disable iff (!nrst)
    st_wr && ctrl_r.combine && !clr |=> st_rp_r == $past(st_rp_r) + 4'h1
    && st_wp_r == $past(st_wp_r) + 4'h1)
    else $error("combine write did not step both pointers");
  busy_refuse_a: assert property (@(posedge clk) disable iff (!nrst)
    busy && wr && hit_key && !clr |=> $stable(key_wp_r))
    else $error("key port taken while running");
  done_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    done_p && !clr |=> rdy_r ##1 evt_o.dma_trig == 1'b0)
    else $error("completion did not set ready");
  dma_trig_a: assert property (@(posedge clk) disable iff (!nrst)
    evt_o.dma_trig |-> $past(busy) && !busy)
    else $error("dma trigger without completion");
  start_clr_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(err_r) || $rose(rdy_r) |-> !busy)
    else $error("start stayed set after flag");
  srst_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    clr |=> !clr && st_wp_r == 4'h0 && !rdy_r && state_mem[0] == 8'h00)
    else $error("soft reset did not clear state");
  err_frac_a: assert property (@(posedge clk) disable iff (!nrst)
    start_req && frac_bad && !clr |=> err_r && !busy)
    else $error("partial load start not flagged");
  err_ctrl_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_acc && busy && !clr |=> err_r)
    else $error("control access while running not flagged");
  irq_req_a: assert property (@(posedge clk) disable iff (!nrst)
    rdy_r && irq_priority_level_r != 2'h0 && !clr |=> evt_o.irq_req)
    else $error("interrupt not requested");
endmodule : bce_core

// ===== design/bce_pkg.sv
// Types shared by the block cipher engine.
package bce_pkg;
  typedef struct packed {
    logic start;
    logic auto_go;
    logic sw_reset;
    logic decrypt;
    logic rsv3;
    logic combine;
    logic [1:0] rsv;
  } bce_ctrl_t;
  typedef struct packed {
    logic irq_req;
    logic dma_trig;
  } bce_evt_t;
endpackage : bce_pkg

// ===== design/bce_regs.svh
// Register indices, field positions, reset values and timing counts.
`ifndef BCE_REGS_SVH
`define BCE_REGS_SVH
`define BCE_IDX_CTRL 3'h0
`define BCE_IDX_FLAGS 3'h1
`define BCE_IDX_STATE 3'h2
`define BCE_IDX_KEY 3'h3
`define BCE_IDX_INTCTRL 3'h4
`define BCE_CTRL_WMASK 8'hF4
`define BCE_CTRL_RST 8'h00
`define BCE_FLAGS_RST 8'h00
`define BCE_FLAG_ERR 7
`define BCE_FLAG_RDY 0
`define BCE_RUN_CYCLES 9'h177
`define BCE_RUN_LAST (`BCE_RUN_CYCLES - 9'h001)
`define BCE_ROUND_LAST 9'h00A
`define BCE_RCON_FIRST 8'h01
`define BCE_RCON_LAST 8'h36
`endif
